// *** frd_map.vh ***
`ifndef FRD_MAP_VH
`define FRD_MAP_VH
// opcodes
`define FRD_OP_RESET_ARM    8'h66
`define FRD_OP_RESET        8'h99
`define FRD_OP_NOP          8'h00
`define FRD_OP_UID_READ     8'h4b
`define FRD_OP_TABLE_READ   8'h5a
// command framing
`define FRD_UID_DUMMY_BYTES 3'd4
`define FRD_TBL_ADDR_BYTES  3'd3
`define FRD_TBL_DUMMY_BYTES 3'd1
`define FRD_UID_BITS        8'd128
// timing
`define FRD_CLK_MHZ         250
`define FRD_RESET_LOW_US    1
`define FRD_RESET_LOW_CYC   (`FRD_RESET_LOW_US * `FRD_CLK_MHZ)
// discovery header area
`define FRD_HDR_LAST        8'h17
`define FRD_HDR_FILL        8'hff
`endif

// *** frd_hdr_rom.v ***
`timescale 1ns/1ns
`include "frd_map.vh"
module frd_hdr_rom #(
  parameter [7:0] VENDOR_ID = 8'h5c  // arbitrary neutral value
) (
  input  wire [7:0] addr_i,
  output reg  [7:0] data_o
);
  always @* begin
    case (addr_i)
      8'h00: data_o = 8'h53;
      8'h01: data_o = 8'h46;
      8'h02: data_o = 8'h44;
      8'h03: data_o = 8'h50;
      8'h04: data_o = 8'h00;
      8'h05: data_o = 8'h01;
      8'h06: data_o = 8'h01;
      8'h08: data_o = 8'h00;
      8'h09: data_o = 8'h00;
      8'h0a: data_o = 8'h01;
      8'h0b: data_o = 8'h09;
      8'h0c: data_o = 8'h30;
      8'h0d: data_o = 8'h00;
      8'h0e: data_o = 8'h00;
      8'h10: data_o = VENDOR_ID;
      8'h11: data_o = 8'h00;
      8'h12: data_o = 8'h01;
      8'h13: data_o = 8'h03;
      8'h14: data_o = 8'h60;
      8'h15: data_o = 8'h00;
      8'h16: data_o = 8'h00;
      default: data_o = `FRD_HDR_FILL;
    endcase
  end
endmodule // frd_hdr_rom

// *** frd_cmd.v ***
`timescale 1ns/1ns
`include "frd_map.vh"
module frd_cmd #(
  parameter [127:0] UNIQUE_ID     = 128'h0123456789abcdeffedcba9876543210,
  parameter [7:0]   VENDOR_ID     = 8'h5c,
  parameter integer RESET_LOW_CYC = `FRD_RESET_LOW_CYC
) (
  input  wire clk_sys_i,
  input  wire rst_n_i,
  input  wire reset_pin_n_i,
  input  wire cs_n_i,
  input  wire sclk_i,
  input  wire si_i,
  input  wire wr_busy_i,
  input  wire wel_set_i,
  input  wire lock_all_i,
  output reg  so_o,
  output reg  so_oe_o,
  output reg  write_enable_latch_o,
  output reg  write_in_progress_o,
  output reg  block_lock_o,
  output reg  abort_o,
  output reg  reset_arm_o,
  output reg  in_reset_o
);
  localparam [2:0] ST_OPC = 3'd0;
  localparam [2:0] ST_UID_DUMMY = 3'd1;
  localparam [2:0] ST_UID_OUT = 3'd2;
  localparam [2:0] ST_TBL_ADDR = 3'd3;
  localparam [2:0] ST_TBL_DUMMY = 3'd4;
  localparam [2:0] ST_TBL_OUT = 3'd5;
  localparam [2:0] ST_IGNORE = 3'd6;
  localparam [0:0] WEL_DEFAULT  = 1'b0;
  localparam [0:0] WIP_DEFAULT  = 1'b0;
  localparam [0:0] LOCK_DEFAULT = 1'b1;

  reg  [2:0]  state_reg;
  reg  [2:0]  bit_cnt_reg;
  reg  [2:0]  byte_cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  addr_reg;
  reg  [7:0]  out_byte_reg;
  reg  [6:0]  uid_idx_reg;
  reg         sclk_d_reg;
  reg  [31:0] low_cnt_reg;
  wire [7:0]  rom_data;
  wire        rise;
  wire        fall;
  wire [7:0]  byte_in;
  wire        byte_done;
  wire        pin_reset;
  reg         sw_reset;

  assign rise      = sclk_i & ~sclk_d_reg & ~cs_n_i;
  assign fall      = ~sclk_i & sclk_d_reg & ~cs_n_i;
  assign byte_in   = {shift_reg[6:0], si_i};
  assign byte_done = rise & (bit_cnt_reg == 3'd7);
  assign pin_reset = ~reset_pin_n_i;

  frd_hdr_rom #(.VENDOR_ID(VENDOR_ID)) u_rom (
    .addr_i (addr_reg),
    .data_o (rom_data)
  );

  // id bits, picked msb first by index
  wire [127:0] uid_vec;
  genvar       g;
  generate
    for (g = 0; g < 128; g = g + 1) begin : g_uid
      assign uid_vec[g] = UNIQUE_ID[g];
    end
  endgenerate

  // opcode decode of the byte completing on this edge
  wire        op_arm;
  wire        op_reset;
  wire        op_uid;
  wire        op_tbl;

  assign op_arm   = (byte_in == `FRD_OP_RESET_ARM);
  assign op_reset = (byte_in == `FRD_OP_RESET);
  assign op_uid   = (byte_in == `FRD_OP_UID_READ);
  assign op_tbl   = (byte_in == `FRD_OP_TABLE_READ);

  always @* begin
    sw_reset = 1'b0;
    if (state_reg == ST_OPC && byte_done && op_reset && reset_arm_o)
      sw_reset = 1'b1;
  end

  // reset pin low-time counter
  reg  [31:0] low_cnt_next;
  reg         in_reset_next;

  always @* begin
    low_cnt_next  = low_cnt_reg;
    in_reset_next = in_reset_o;
    if (pin_reset) begin
      if (low_cnt_reg < RESET_LOW_CYC)
        low_cnt_next = low_cnt_reg + 32'd1;
      else
        in_reset_next = 1'b1;
    end else begin
      low_cnt_next  = 32'd0;
      in_reset_next = 1'b0;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_reg  <= 1'b0;
      low_cnt_reg <= 32'd0;
      in_reset_o  <= 1'b0;
    end else begin
      sclk_d_reg  <= sclk_i;
      low_cnt_reg <= low_cnt_next;
      in_reset_o  <= in_reset_next;
    end
  end

  // volatile status flags, power-on values restored by either reset
  reg         wel_next;
  reg         wip_next;
  reg         lock_next;
  reg         abort_next;
  reg         arm_next;

  always @* begin
    wel_next   = write_enable_latch_o;
    wip_next   = wr_busy_i;
    lock_next  = block_lock_o;
    abort_next = 1'b0;
    arm_next   = reset_arm_o;
    if (pin_reset) begin
      wel_next   = WEL_DEFAULT;
      wip_next   = WIP_DEFAULT;
      lock_next  = LOCK_DEFAULT;
      abort_next = write_in_progress_o;
      arm_next   = 1'b0;
    end else if (sw_reset) begin
      wel_next   = WEL_DEFAULT;
      wip_next   = WIP_DEFAULT;
      lock_next  = LOCK_DEFAULT;
      abort_next = write_in_progress_o;
      arm_next   = 1'b0;
    end else begin
      if (wel_set_i)
        wel_next = 1'b1;
      if (lock_all_i)
        lock_next = 1'b1;
      if (state_reg == ST_OPC && byte_done)
        arm_next = op_arm;
    end
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      write_enable_latch_o <= WEL_DEFAULT;
      write_in_progress_o  <= WIP_DEFAULT;
      block_lock_o         <= LOCK_DEFAULT;
      abort_o              <= 1'b0;
      reset_arm_o          <= 1'b0;
    end else begin
      write_enable_latch_o <= wel_next;
      write_in_progress_o  <= wip_next;
      block_lock_o         <= lock_next;
      abort_o              <= abort_next;
      reset_arm_o          <= arm_next;
    end
  end

  // serial input shifter
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_reg <= 3'd0;
      shift_reg   <= 8'h00;
    end else if (pin_reset || sw_reset || cs_n_i) begin
      bit_cnt_reg <= 3'd0;
    end else if (rise) begin
      shift_reg   <= byte_in;
      bit_cnt_reg <= bit_cnt_reg + 3'd1;
    end
  end

  // command sequencer and serial output
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg    <= ST_OPC;
      byte_cnt_reg <= 3'd0;
      addr_reg     <= 8'h00;
      out_byte_reg <= 8'h00;
      uid_idx_reg  <= 7'd0;
      so_o         <= 1'b0;
      so_oe_o      <= 1'b0;
    end else if (pin_reset) begin
      state_reg <= ST_OPC;
      so_oe_o   <= 1'b0;
      so_o      <= 1'b0;
    end else if (sw_reset) begin
      state_reg <= ST_OPC;
      so_oe_o   <= 1'b0;
    end else begin
      if (cs_n_i) begin
        state_reg <= ST_OPC;
        so_oe_o   <= 1'b0;
      end else begin
        case (state_reg)
          // opcode byte
          ST_OPC: begin
            if (byte_done) begin
              byte_cnt_reg <= 3'd0;
              if (op_uid)
                state_reg <= ST_UID_DUMMY;
              else if (op_tbl)
                state_reg <= ST_TBL_ADDR;
              else
                state_reg <= ST_IGNORE;
            end
          end
          ST_UID_DUMMY: begin
            if (byte_done) begin
              byte_cnt_reg <= byte_cnt_reg + 3'd1;
              if (byte_cnt_reg == `FRD_UID_DUMMY_BYTES - 3'd1) begin
                state_reg   <= ST_UID_OUT;
                uid_idx_reg <= 7'd127;
              end
            end
          end
          ST_UID_OUT: begin
            if (fall) begin
              so_oe_o     <= 1'b1;
              so_o        <= uid_vec[uid_idx_reg];
              uid_idx_reg <= uid_idx_reg - 7'd1;
              if (uid_idx_reg == 7'd0)
                state_reg <= ST_IGNORE;
            end
          end
          ST_TBL_ADDR: begin
            if (byte_done) begin
              byte_cnt_reg <= byte_cnt_reg + 3'd1;
              addr_reg     <= byte_in;
              if (byte_cnt_reg == `FRD_TBL_ADDR_BYTES - 3'd1) begin
                state_reg    <= ST_TBL_DUMMY;
                byte_cnt_reg <= 3'd0;
              end
            end
          end
          ST_TBL_DUMMY: begin
            if (byte_done) begin
              state_reg    <= ST_TBL_OUT;
              out_byte_reg <= rom_data;
              addr_reg     <= addr_reg + 8'h01;
            end
          end
          ST_TBL_OUT: begin
            if (fall) begin
              so_oe_o      <= 1'b1;
              so_o         <= out_byte_reg[7];
              out_byte_reg <= {out_byte_reg[6:0], 1'b0};
            end
            if (byte_done) begin
              out_byte_reg <= rom_data;
              addr_reg     <= addr_reg + 8'h01;
            end
          end
          ST_IGNORE: begin
            if (fall)
              so_oe_o <= 1'b0;  // last id bit stands a full sclk cycle
          end
          default: begin
            state_reg <= ST_IGNORE;
            so_oe_o   <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // frd_cmd

// *** frd_cmd_monitor.sv ***
`timescale 1ns/1ns
module frd_cmd_monitor #(
  parameter integer RESET_LOW_CYC = 250
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire reset_pin_n_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire si_i,
  input wire wr_busy_i,
  input wire wel_set_i,
  input wire lock_all_i,
  input wire so_o,
  input wire so_oe_o,
  input wire write_enable_latch_o,
  input wire write_in_progress_o,
  input wire block_lock_o,
  input wire abort_o,
  input wire reset_arm_o,
  input wire in_reset_o
);
  // counts clock cycles with the reset pin low
  reg [15:0] low_reg;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) low_reg <= 16'h0000;
    else low_reg <= reset_pin_n_i ? 16'h0000 : low_reg + 16'h0001;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_pin_off; !reset_pin_n_i [*2] |-> !so_oe_o; endproperty
  a_pin_off: assert property (p_pin_off) else $error("so driven in pin reset");
  property p_cs_off; cs_n_i [*2] |-> !so_oe_o; endproperty
  a_cs_off: assert property (p_cs_off) else $error("so driven while deselected");
  property p_rst_early; $rose(in_reset_o) |-> low_reg >= RESET_LOW_CYC - 1; endproperty
  a_rst_early: assert property (p_rst_early) else $error("pin reset too early");
  property p_rst_late; low_reg == RESET_LOW_CYC + 2 |-> in_reset_o; endproperty
  a_rst_late: assert property (p_rst_late) else $error("pin reset missing");
  property p_pin_clr; in_reset_o |-> !write_enable_latch_o && block_lock_o; endproperty
  a_pin_clr: assert property (p_pin_clr) else $error("state kept in reset");
  property p_abort_pin;
    $fell(reset_pin_n_i) && wr_busy_i && write_in_progress_o |-> ##[0:2] abort_o;
  endproperty
  a_abort_pin: assert property (p_abort_pin) else $error("no abort on pin");
  property p_abort_why;
    abort_o |-> !$past(reset_pin_n_i) || $past(reset_arm_o) && $past(write_in_progress_o);
  endproperty
  a_abort_why: assert property (p_abort_why) else $error("abort without cause");
  property p_so_edge; $changed(so_o) && $past(so_oe_o) && so_oe_o |-> !$past(sclk_i); endproperty
  a_so_edge: assert property (p_so_edge) else $error("so moved off falling edge");
  c_abort: cover property (abort_o);
  c_in_reset: cover property ($rose(in_reset_o));
  c_drive: cover property ($rose(so_oe_o));
endmodule  // frd_cmd_monitor
bind frd_cmd frd_cmd_monitor #(.RESET_LOW_CYC(RESET_LOW_CYC)) u_mon (
  .clk_sys_i            (clk_sys_i),
  .rst_n_i              (rst_n_i),
  .reset_pin_n_i        (reset_pin_n_i),
  .cs_n_i               (cs_n_i),
  .sclk_i               (sclk_i),
  .si_i                 (si_i),
  .wr_busy_i            (wr_busy_i),
  .wel_set_i            (wel_set_i),
  .lock_all_i           (lock_all_i),
  .so_o                 (so_o),
  .so_oe_o              (so_oe_o),
  .write_enable_latch_o (write_enable_latch_o),
  .write_in_progress_o  (write_in_progress_o),
  .block_lock_o         (block_lock_o),
  .abort_o              (abort_o),
  .reset_arm_o          (reset_arm_o),
  .in_reset_o           (in_reset_o)
);

// *** frd_host_model.sv ***
`timescale 1ns/1ns
module frd_host_model #(
  parameter integer RECOV_CYC = 7500
) (
  input  wire clk_sys_i,
  input  wire so_i,
  output reg  cs_n_o,
  output reg  sclk_o,
  output reg  si_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // select changes on byte boundaries, clock parked low
  task sel(input on);
    begin
      repeat (3) @(posedge clk_sys_i);
      #1 cs_n_o = ~on;
      sclk_o = 1'b0;
    end
  endtask
  task recover;
    begin
      // register writes are cut by a reset in t_sw and t_pin, and all get this same wait of RECOV_CYC cycles
      repeat (RECOV_CYC) @(posedge clk_sys_i);
      #1;
    end
  endtask
  // one byte msb first, so sampled before each rising edge
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sclk_o = 1'b0;
        si_o = tx[i];
        repeat (3) @(posedge clk_sys_i);
        rx[i] = so_i;
        #1 sclk_o = 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1;
      end
    end
  endtask
endmodule  // frd_host_model

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
  localparam [127:0] UID = 128'h0123456789abcdeffedcba9876543210;
  localparam [7:0]   VID = 8'h5c;  // arbitrary value
  reg  clk_sys_i = 1'b0, rst_n_i = 1'b0, reset_pin_n_i = 1'b1;
  reg  wr_busy_i = 1'b0, wel_set_i = 1'b0, lock_all_i = 1'b0;
  reg  seen = 1'b0, junk = 1'b0;
  reg  [7:0] rx;
  wire cs_n_i, sclk_i, si_i, so_o, so_oe_o, write_enable_latch_o, write_in_progress_o;
  wire block_lock_o, abort_o, reset_arm_o, in_reset_o;
  wire so_w = (so_oe_o === 1'b1) ? so_o : junk;
  wire [191:0] tbl = {56'hff000060030100, VID, 64'hff00003009010000, 64'hff01010050444653};
  integer err_total = 0, samples_checked = 0, i;
`define CHK(a, e) begin samples_checked = samples_checked + 1; if ((a) !== (e)) begin \
  err_total = err_total + 1; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    junk <= ~junk;
    if (abort_o === 1'b1) seen <= 1'b1;
  end
  frd_cmd #(.UNIQUE_ID(UID), .VENDOR_ID(VID), .RESET_LOW_CYC(4)) DUT (
    .clk_sys_i            (clk_sys_i),
    .rst_n_i              (rst_n_i),
    .reset_pin_n_i        (reset_pin_n_i),
    .cs_n_i               (cs_n_i),
    .sclk_i               (sclk_i),
    .si_i                 (si_i),
    .wr_busy_i            (wr_busy_i),
    .wel_set_i            (wel_set_i),
    .lock_all_i           (lock_all_i),
    .so_o                 (so_o),
    .so_oe_o              (so_oe_o),
    .write_enable_latch_o (write_enable_latch_o),
    .write_in_progress_o  (write_in_progress_o),
    .block_lock_o         (block_lock_o),
    .abort_o              (abort_o),
    .reset_arm_o          (reset_arm_o),
    .in_reset_o           (in_reset_o)
  );
  frd_host_model host (.clk_sys_i(clk_sys_i), .so_i(so_w), .cs_n_o(cs_n_i),
                       .sclk_o(sclk_i), .si_o(si_i));
  task cmd(input [7:0] op);
    begin
      host.sel(1);
      host.xfer(op, rx);
      host.sel(0);
    end
  endtask
  task wel_pulse;
    begin
      wel_set_i = 1'b1;
      @(posedge clk_sys_i);
      #1 wel_set_i = 1'b0;
    end
  endtask
  task t_uid;
    begin
      host.sel(1);
      host.xfer(8'h4b, rx);
      for (i = 0; i < 4; i = i + 1) host.xfer(8'h00, rx);
      for (i = 15; i >= 0; i = i - 1) begin
        host.xfer(8'h00, rx);
        `CHK(rx, UID[i*8+:8])
      end
      host.sel(0);
      repeat (2) @(posedge clk_sys_i);
      `CHK(so_oe_o, 1'b0)
    end
  endtask
  task t_tbl(input [7:0] a, input integer n);
    begin
      host.sel(1);
      host.xfer(8'h5a, rx);
      host.xfer(8'h00, rx);
      host.xfer(8'h00, rx);
      host.xfer(a, rx);
      host.xfer(8'hff, rx);
      for (i = a; i < a + n; i = i + 1) begin
        host.xfer(8'h00, rx);
        `CHK(rx, tbl[i*8+:8])
      end
      host.sel(0);
      repeat (2) @(posedge clk_sys_i);
      `CHK(so_oe_o, 1'b0)
    end
  endtask
  task t_sw;
    begin
      lock_all_i = 1'b1;
      @(posedge clk_sys_i);
      #1 lock_all_i = 1'b0;
      `CHK(block_lock_o, 1'b1)
      wel_pulse;
      cmd(8'h66);
      `CHK(reset_arm_o, 1'b1)
      cmd(8'h00);
      `CHK(reset_arm_o, 1'b0)
      cmd(8'h99);
      `CHK(write_enable_latch_o, 1'b1)
      wr_busy_i = 1'b1;
      cmd(8'h66);
      cmd(8'h99);
      wr_busy_i = 1'b0;
      `CHK({seen, write_enable_latch_o, reset_arm_o}, 3'b100)
      host.recover;
    end
  endtask
  task t_pin;
    begin
      wel_pulse;
      wr_busy_i = 1'b1;
      seen = 1'b0;
      host.sel(1);
      host.xfer(8'h4b, rx);
      for (i = 0; i < 5; i = i + 1) host.xfer(8'h00, rx);
      `CHK(so_oe_o, 1'b1)
      reset_pin_n_i = 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1 `CHK(so_oe_o, 1'b0)
      wr_busy_i = 1'b0;
      repeat (8) @(posedge clk_sys_i);
      #1 `CHK({seen, in_reset_o}, 2'b11)
      `CHK({write_enable_latch_o, write_in_progress_o, block_lock_o}, 3'b001)
      host.sel(0);
      reset_pin_n_i = 1'b1;
      host.recover;
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    host.recover;
    t_uid;
    t_tbl(8'h00, 24);
    t_tbl(8'h13, 3);
    t_sw;
    t_pin;
    t_uid;
    print_verdict;
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    print_verdict;
  end
endmodule  // tb
